//--- core/sdc_pkg.sv
// Shared constants and types for the segment display scan controller.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package sdc_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [15:0] SDC_IDX_DIV_LO = 16'hA120;
  localparam logic [15:0] SDC_IDX_DIV_HI = 16'hA121;
  localparam logic [15:0] SDC_IDX_CFG_A  = 16'hA122;
  localparam logic [15:0] SDC_IDX_CFG_B  = 16'hA123;

  // Reset values of the registers.
  localparam logic [7:0] SDC_RST_DIV_LO = 8'h00;
  localparam logic [7:0] SDC_RST_DIV_HI = 8'h00;
  localparam logic [7:0] SDC_RST_CFG_A  = 8'h00;
  localparam logic [7:0] SDC_RST_CFG_B  = 8'h00;

  // Field positions in the divider high register.
  localparam int SDC_HI_SRC_BIT  = 7;
  localparam int SDC_HI_MODE_LSB = 5;
  localparam int SDC_HI_BRT_BIT  = 4;

  // Field positions in configuration register A.
  localparam int SDC_A_PIN_LSB   = 4;
  localparam int SDC_A_BLANK_BIT = 3;
  localparam int SDC_A_IRQEN_BIT = 1;
  localparam int SDC_A_FLAG_BIT  = 0;

  // Field positions in configuration register B.
  localparam int SDC_B_BIAS_LSB = 6;
  localparam int SDC_B_BRT_LSB  = 4;

  // Width of the pixel divider and the fixed LED prescaler.
  localparam int         SDC_DIV_W          = 12;
  localparam int         SDC_PRESCALE_W     = 8;
  localparam int         SDC_LED_PRESCALE   = 256;
  localparam logic [7:0] SDC_PRESCALE_LIMIT = 8'(SDC_LED_PRESCALE - 1);

  // Operating modes selected by the two-bit mode field.
  typedef enum logic [1:0] {
    SDC_MODE_OFF     = 2'h0,
    SDC_MODE_LCD     = 2'h1,
    SDC_MODE_LED_EXT = 2'h2,
    SDC_MODE_LED_DIR = 2'h3
  } sdc_mode_t;

endpackage

//--- core/sdc_rate_div.sv
// Tick divider: emits one pulse for every limit+1 input ticks.
// Assumes the input tick is a one-cycle pulse in the core clock domain.
`timescale 1ns/10ps
module sdc_rate_div #(
  parameter int W = 12
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_tick,
  input  wire logic [W-1:0] i_limit,
  output logic              o_pulse
);
  logic [W-1:0] cnt_q;

  // Refuse counter widths the wrap compare was not sized for, at elaboration.
  if (W < 1 || W > 16) begin : g_bad_width
    $error("sdc_rate_div: W out of range");
  end

  // The wrap test uses >= so that lowering the limit never strands the count.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cnt_q   <= '0;
      o_pulse <= 1'b0;
    end else begin
      o_pulse <= 1'b0;
      if (i_tick) begin
        if (cnt_q >= i_limit) begin
          cnt_q   <= '0;
          o_pulse <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end
endmodule

//--- core/sdc_scan_ctrl.sv
// Top of the segment display scan controller: registers, clock choice, scan and blanking.
// Assumes a classic Wishbone master on the core clock and slow source clocks on pins.
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/10ps

// Overview of operation
// - Divider low byte fills one register, upper four bits sit low in the next.
// - In LED modes pixel rate is system clock over 256 over divider plus one.
// - In LCD mode source choice 0 picks real-time clock, 1 the slow oscillator.
// - In LED modes the source choice is ignored and the system clock is used.
// - Each shared pin enable set gives a common output, clear gives a segment.
// - Blank drives all segment and common outputs inactive; scanning still runs.
// - Frame interrupt enable gates the frame flag onto the interrupt request.
// - Hardware sets the frame flag at every frame end regardless of enable.
// - Only software clears the flag, by writing 0, at the next scan clock edge.
// - LCD and external-drive frames span one pixel slot per duty phase.
// - Direct-drive frames span one pixel slot per active digit.
// - LCD brightness is a three-bit field whose top bit is in the high register.
// - Active digit count is the digit field plus one, starting at the first.
// - Phases scan from 0 up to N and wrap; N is 0 to 7 from duty, or 0 to 15 from the digit field in direct drive.
module sdc_scan_ctrl #(
  parameter int ADR_W = 18
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_rtc_clk,
  input  wire logic              i_slow_osc_clk,
  input  wire logic              i_wb_cyc,
  input  wire logic              i_wb_stb,
  input  wire logic              i_wb_we,
  input  wire logic [ADR_W-1:0]  i_wb_adr,
  input  wire logic [3:0]        i_wb_sel,
  input  wire logic [31:0]       i_wb_dat,
  input  wire logic [31:0]       i_seg_data,
  output logic [31:0]            o_wb_dat,
  output logic                   o_wb_ack,
  output logic [7:0]             o_com,
  output logic [27:0]            o_seg,
  output logic [3:0]             o_shared_pin,
  output logic [3:0]             o_shared_is_com,
  output logic [15:0]            o_digit_sel,
  output logic [3:0]             o_scan_phase,
  output logic                   o_frame_irq,
  output logic [2:0]             o_brightness,
  output logic [1:0]             o_bias,
  output sdc_pkg::sdc_mode_t     o_mode
);
  import sdc_pkg::*;

  // A narrower address bus cannot reach the register map, so elaboration stops.
  if (ADR_W < 18) begin : g_bad_adr
    $error("sdc_scan_ctrl: ADR_W must be at least 18");
  end

  logic [7:0]  div_lo_q;
  logic [3:0]  div_hi_q;
  logic        src_choice_q;
  sdc_mode_t   mode_q;
  logic        brt_hi_q;
  logic [3:0]  pin_com_en_q;
  logic        blank_q;
  logic        irq_en_q;
  logic        flag_q;
  logic        clr_pend_q;
  logic [7:0]  cfg_b_q;
  logic [3:0]  phase_q;
  logic        rtc_s;
  logic        osc_s;
  logic        rtc_d_q;
  logic        osc_d_q;
  logic        rtc_rise;
  logic        osc_rise;
  logic        led_mode;
  logic        lcd_mode;
  logic        dir_mode;
  logic        pre_pulse;
  logic        src_tick;
  logic        scan_edge;
  logic        pix_pulse;
  logic [3:0]  last_phase;
  logic        frame_end;
  logic        req;
  logic        wr;
  logic        hit_lo;
  logic        hit_hi;
  logic        hit_a;
  logic        hit_b;
  logic [7:0]  rd_byte;
  logic        drive_en;
  logic [7:0]  com_next;

  // Source clocks come from pins and pass two flops before anything reads them.
  sdc_sync2 u_rtc_sync (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_async    (i_rtc_clk),
    .o_sync     (rtc_s)
  );
  sdc_sync2 u_osc_sync (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_async    (i_slow_osc_clk),
    .o_sync     (osc_s)
  );

  // Rising edges of the synchronised source clocks.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rtc_d_q <= 1'b0;
      osc_d_q <= 1'b0;
    end else begin
      rtc_d_q <= rtc_s;
      osc_d_q <= osc_s;
    end
  end
  assign rtc_rise = rtc_s & ~rtc_d_q;
  assign osc_rise = osc_s & ~osc_d_q;

  // Mode decode.
  assign lcd_mode = (mode_q == SDC_MODE_LCD);
  assign dir_mode = (mode_q == SDC_MODE_LED_DIR);
  assign led_mode = (mode_q == SDC_MODE_LED_EXT) || dir_mode;

  // The system clock is prescaled by 256 only while an LED mode is active.
  sdc_rate_div #(.W(SDC_PRESCALE_W)) u_prescale (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_tick     (led_mode),
    .i_limit    (SDC_PRESCALE_LIMIT),
    .o_pulse    (pre_pulse)
  );

  // Scan clock tick; in LED modes the source choice bit has no effect.
  always_comb begin
    if (lcd_mode) begin
      src_tick = src_choice_q ? osc_rise : rtc_rise;
    end else if (led_mode) begin
      src_tick = pre_pulse;
    end else begin
      src_tick = 1'b0;
    end
  end

  // The pixel divider counts scan clock ticks, limit is the 12-bit value.
  sdc_rate_div #(.W(SDC_DIV_W)) u_pixel_div (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_tick     (src_tick),
    .i_limit    ({div_hi_q, div_lo_q}),
    .o_pulse    (pix_pulse)
  );

  // Last phase of a frame: duty phases or active digits.
  assign last_phase = dir_mode ? cfg_b_q[3:0] : {1'b0, cfg_b_q[2:0]};
  assign frame_end  = pix_pulse && (mode_q != SDC_MODE_OFF) && (phase_q >= last_phase);

  // Phase counter wraps after the last phase; it keeps running while blanked.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      phase_q <= 4'h0;
    end else if (mode_q == SDC_MODE_OFF) begin
      phase_q <= 4'h0;
    end else if (pix_pulse) begin
      phase_q <= (phase_q >= last_phase) ? 4'h0 : phase_q + 4'h1;
    end
  end

  // Bus decode; the ack is registered, so every access takes one wait state.
  assign req    = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wr     = req && i_wb_we && i_wb_sel[0];
  assign hit_lo = (i_wb_adr[ADR_W-1:2] == (ADR_W-2)'(SDC_IDX_DIV_LO));
  assign hit_hi = (i_wb_adr[ADR_W-1:2] == (ADR_W-2)'(SDC_IDX_DIV_HI));
  assign hit_a  = (i_wb_adr[ADR_W-1:2] == (ADR_W-2)'(SDC_IDX_CFG_A));
  assign hit_b  = (i_wb_adr[ADR_W-1:2] == (ADR_W-2)'(SDC_IDX_CFG_B));

  // Read data mux; unmapped addresses and the reserved bit read as zero.
  always_comb begin
    rd_byte = 8'h00;
    if (hit_lo) begin
      rd_byte = div_lo_q;
    end else if (hit_hi) begin
      rd_byte = {src_choice_q, mode_q, brt_hi_q, div_hi_q};
    end else if (hit_a) begin
      rd_byte = {pin_com_en_q, blank_q, 1'b0, irq_en_q, flag_q};
    end else if (hit_b) begin
      rd_byte = cfg_b_q;
    end
  end

  // Answer every request, mapped or not, one cycle after it is seen.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= req;
      o_wb_dat <= req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Software-written configuration.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      div_lo_q     <= SDC_RST_DIV_LO;
      div_hi_q     <= SDC_RST_DIV_HI[3:0];
      brt_hi_q     <= SDC_RST_DIV_HI[SDC_HI_BRT_BIT];
      mode_q       <= sdc_mode_t'(SDC_RST_DIV_HI[SDC_HI_MODE_LSB +: 2]);
      src_choice_q <= SDC_RST_DIV_HI[SDC_HI_SRC_BIT];
      pin_com_en_q <= SDC_RST_CFG_A[SDC_A_PIN_LSB +: 4];
      blank_q      <= SDC_RST_CFG_A[SDC_A_BLANK_BIT];
      irq_en_q     <= SDC_RST_CFG_A[SDC_A_IRQEN_BIT];
      cfg_b_q      <= SDC_RST_CFG_B;
    end else if (wr) begin
      if (hit_lo) begin
        div_lo_q <= i_wb_dat[7:0];
      end
      if (hit_hi) begin
        div_hi_q     <= i_wb_dat[3:0];
        brt_hi_q     <= i_wb_dat[SDC_HI_BRT_BIT];
        mode_q       <= sdc_mode_t'(i_wb_dat[SDC_HI_MODE_LSB +: 2]);
        src_choice_q <= i_wb_dat[SDC_HI_SRC_BIT];
      end
      if (hit_a) begin
        pin_com_en_q <= i_wb_dat[SDC_A_PIN_LSB +: 4];
        blank_q      <= i_wb_dat[SDC_A_BLANK_BIT];
        irq_en_q     <= i_wb_dat[SDC_A_IRQEN_BIT];
      end
      if (hit_b) begin
        cfg_b_q <= i_wb_dat[7:0];
      end
    end
  end

  // The display clock is the system clock itself in LED modes, the chosen source edge in LCD mode.
  assign scan_edge = led_mode || src_tick;

  // A clear request waits for the next display clock edge, as the flag lives on that clock.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      clr_pend_q <= 1'b0;
    end else if (wr && hit_a && !i_wb_dat[SDC_A_FLAG_BIT]) begin
      clr_pend_q <= 1'b1;
    end else if (scan_edge) begin
      clr_pend_q <= 1'b0;
    end
  end

  // Frame flag: a frame end in the clearing cycle wins, so no frame is lost.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      flag_q <= SDC_RST_CFG_A[SDC_A_FLAG_BIT];
    end else if (frame_end) begin
      flag_q <= 1'b1;
    end else if (clr_pend_q && scan_edge) begin
      flag_q <= 1'b0;
    end
  end

  // Interrupt request is the flag gated by its enable.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_frame_irq <= 1'b0;
    end else begin
      o_frame_irq <= flag_q && irq_en_q;
    end
  end

  // Drive selects; blanking only gates the pins, the scan keeps going.
  assign drive_en = !blank_q && (mode_q != SDC_MODE_OFF);
  assign com_next = (drive_en && !dir_mode) ? (8'h01 << phase_q[2:0]) : 8'h00;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_com           <= 8'h00;
      o_seg           <= 28'h000_0000;
      o_digit_sel     <= 16'h0000;
      o_shared_pin    <= 4'h0;
      o_shared_is_com <= 4'h0;
      o_scan_phase    <= 4'h0;
      o_brightness    <= 3'h0;
      o_bias          <= 2'h0;
      o_mode          <= SDC_MODE_OFF;
    end else begin
      o_com           <= com_next;
      o_seg           <= drive_en ? i_seg_data[27:0] : 28'h000_0000;
      o_digit_sel     <= (drive_en && dir_mode) ? (16'h0001 << phase_q) : 16'h0000;
      o_shared_is_com <= pin_com_en_q;
      // Pin k pairs common 4+k with segment 31-k.
      for (int k = 0; k < 4; k++) begin
        o_shared_pin[k] <= pin_com_en_q[k] ? com_next[4 + k]
                         : (drive_en && i_seg_data[31 - k]);
      end
      o_scan_phase    <= phase_q;
      o_brightness    <= {brt_hi_q, cfg_b_q[SDC_B_BRT_LSB +: 2]};
      o_bias          <= cfg_b_q[SDC_B_BIAS_LSB +: 2];
      o_mode          <= mode_q;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  a_flag_on_frame: assert property (frame_end |=> flag_q)
    else $error("frame flag not set at frame end");
  a_irq_gating: assert property (##1 o_frame_irq == $past(flag_q && irq_en_q))
    else $error("interrupt request does not follow flag and enable");
  a_flag_sticky: assert property (flag_q && !(clr_pend_q && scan_edge) |=> flag_q)
    else $error("frame flag cleared without a pending clear");
  a_flag_clears: assert property (flag_q && clr_pend_q && scan_edge && !frame_end |=> !flag_q)
    else $error("pending clear not applied at scan tick");
  a_blank_pins: assert property (blank_q |=> o_com == 8'h00 && o_seg == 28'h000_0000
                                 && o_shared_pin == 4'h0 && o_digit_sel == 16'h0000)
    else $error("outputs active while blanked");
  a_lcd_source: assert property (lcd_mode && src_choice_q |-> src_tick == osc_rise)
    else $error("LCD source choice not honoured");
  a_led_source: assert property (led_mode && (rtc_rise || osc_rise) && !pre_pulse |-> !src_tick)
    else $error("LED mode ticked from a slow source");
  a_phase_wrap: assert property (pix_pulse && mode_q != SDC_MODE_OFF && phase_q >= last_phase
                                 |=> phase_q == 4'h0)
    else $error("phase did not wrap after last phase");
  a_phase_step: assert property (pix_pulse && phase_q < last_phase && mode_q != SDC_MODE_OFF
                                 |=> phase_q == $past(phase_q) + 4'h1)
    else $error("phase did not advance by one");
  a_dir_frame: assert property (frame_end && dir_mode |-> phase_q == cfg_b_q[3:0])
    else $error("direct frame length differs from digit count");
  a_duty_frame: assert property (frame_end && !dir_mode |-> phase_q == {1'b0, cfg_b_q[2:0]})
    else $error("frame length differs from duty");
  a_off_idle: assert property (mode_q == SDC_MODE_OFF |-> !src_tick)
    else $error("scan tick while disabled");
  a_div_split: assert property (wr && hit_hi |=> div_hi_q == $past(i_wb_dat[3:0]))
    else $error("divider high bits not stored");
  a_shared_map: assert property (o_shared_is_com[0] |-> o_shared_pin[0] == o_com[4])
    else $error("shared pin does not carry its common");

  c_lcd_frame: cover property (frame_end && lcd_mode);
  c_dir_frame: cover property (frame_end && dir_mode);
  c_flag_clear: cover property (flag_q ##1 !flag_q);
  c_blank_scan: cover property (blank_q && frame_end);
endmodule

//--- core/sdc_sync2.sv
// Two-flop synchroniser for one slow clock arriving from outside the core domain.
// Assumes the sampled clock is much slower than the core clock.
`timescale 1ns/10ps
module sdc_sync2 (
  input  wire logic i_core_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_q;

  // Only the second flop reads the first one, so metastability stays contained.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      meta_q <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

//--- testbench/sdc_panel_model.sv
// Behavioural model of the segment or LED panel hanging on the scan controller's pins.
// Assumes all pins are active high and sampled on the core clock; the panel drives nothing back.
`timescale 1ns/10ps
module sdc_panel_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [7:0]  i_com,
  input  wire logic [27:0] i_seg,
  input  wire logic [3:0]  i_shared_pin,
  input  wire logic [15:0] i_digit_sel,
  output logic             o_lit,
  output logic [15:0]      o_overlap_cnt
);
  // The glass shows something whenever any pin is driven active.
  assign o_lit = |{i_com, i_seg, i_shared_pin, i_digit_sel};

  // Two commons or two digits on at once would ghost on real glass, so such cycles are counted.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_overlap_cnt <= 16'h0000;
    end else if ($countones(i_com) > 1 || $countones(i_digit_sel) > 1) begin
      o_overlap_cnt <= o_overlap_cnt + 16'h0001;
    end
  end
endmodule

//--- testbench/tb.sv
// Self-checking bench for the scan controller: Wishbone register tasks and scan timing tests.
// Assumes the design package is compiled first and that the panel model sits on the pins.
`timescale 1ns/10ps
module tb;
  import sdc_pkg::*;
  logic        core_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        rtc_clk  = 1'b0;
  logic        osc_clk  = 1'b0;
  logic        cyc      = 1'b0;
  logic        stb      = 1'b0;
  logic        we       = 1'b0;
  logic [17:0] adr      = 18'h00000;
  logic [3:0]  sel      = 4'h0;
  logic [31:0] wdat     = 32'h00000000;
  logic [31:0] seg_data = 32'h5A3C96E1;
  logic [31:0] rdat;
  logic        ack;
  logic [7:0]  com;
  logic [27:0] seg;
  logic [3:0]  shp, shc, phase, p;
  logic [15:0] dig, overlap;
  logic        irq, lit;
  logic [2:0]  brt;
  logic [1:0]  bias;
  sdc_mode_t   mode;
  int          err_total = 0;
  int          total_checks = 0;
  int          cycles = 0;

  sdc_scan_ctrl u_dut (.i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_rtc_clk(rtc_clk),
    .i_slow_osc_clk(osc_clk), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .i_seg_data(seg_data), .o_wb_dat(rdat), .o_wb_ack(ack),
    .o_com(com), .o_seg(seg), .o_shared_pin(shp), .o_shared_is_com(shc), .o_digit_sel(dig),
    .o_scan_phase(phase), .o_frame_irq(irq), .o_brightness(brt), .o_bias(bias), .o_mode(mode));

  sdc_panel_model u_panel (.i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_com(com), .i_seg(seg),
    .i_shared_pin(shp), .i_digit_sel(dig), .o_lit(lit), .o_overlap_cnt(overlap));

  // Core clock at 50 MHz.
  always #10 core_clk = ~core_clk;

  // Source clocks: 10 and 14 core cycles per period, offset so edges never meet the core edge.
  always #100 rtc_clk = ~rtc_clk;
  always #140 osc_clk = ~osc_clk;

  // Whole run takes under 7500 cycles, so a hang is cut at 60000, well past the normal end.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_total++;
      $display("CHECK FAILED run time expected below 60000 seen %0d", cycles);
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One classic cycle; the request is held until ack is sampled, so no answer time is assumed.
  task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d, output logic [31:0] q);
    int n;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'hF;
    wdat <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 64);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 64) chk("bus ack", 32'h1, 32'h0);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, idx, d, q);
  endtask

  task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
    logic [31:0] q;
    wb(1'b0, idx, 8'h00, q);
    chk("register read", {24'h000000, exp}, q);
  endtask

  // Waits for one phase change, then measures the cycles up to the next one.
  task automatic gap(input int exp);
    int n;
    p = phase;
    n = 0;
    while (phase === p && n < 9000) begin @(posedge core_clk); n++; end
    p = phase;
    n = 0;
    while (phase === p && n < 9000) begin @(posedge core_clk); n++; end
    chk("phase gap", 32'(exp), 32'(n));
  endtask

  // Follows cnt phase steps and expects each to be one up, wrapping after last.
  task automatic seq(input int cnt, input logic [3:0] last);
    int k;
    for (int i = 0; i < cnt; i++) begin
      p = phase;
      k = 0;
      while (phase === p && k < 9000) begin @(posedge core_clk); k++; end
      chk("scan phase", 32'(p == last ? 4'h0 : p + 4'h1), 32'(phase));
    end
  endtask

  task automatic tdone(input string name);
    $display("test %s done, mismatches so far %0d", name, err_total);
  endtask

  // Main sequence; every test leaves the block in a state the next one builds on.
  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 4; i++) rdc(SDC_IDX_DIV_LO + 16'(i), 8'h00);
    wr(16'hA12F, 8'hFF);
    rdc(16'hA12F, 8'h00);
    chk("mode", 32'(SDC_MODE_OFF), 32'(mode));
    tdone("reset values");
    wr(SDC_IDX_DIV_LO, 8'hAB);
    wr(SDC_IDX_DIV_HI, 8'h0C);
    rdc(SDC_IDX_DIV_LO, 8'hAB);
    rdc(SDC_IDX_DIV_HI, 8'h0C);
    wr(SDC_IDX_CFG_B, 8'hB2);
    for (int m = 0; m < 4; m++) begin
      wr(SDC_IDX_DIV_HI, {1'b0, 2'(m), 1'b1, 4'h0});
      repeat (2) @(posedge core_clk);
      chk("mode", 32'(m), 32'(mode));
      chk("brightness", 32'h7, 32'(brt));
      chk("bias", 32'h2, 32'(bias));
    end
    tdone("divider and mode fields");
    wr(SDC_IDX_CFG_B, 8'h01);
    wr(SDC_IDX_DIV_LO, 8'h01);
    wr(SDC_IDX_DIV_HI, 8'hC0);
    gap(512);
    seq(4, 4'h1);
    wr(SDC_IDX_CFG_A, 8'h50);
    gap(512);
    repeat (3) @(posedge core_clk);
    chk("shared is common", 32'h5, 32'(shc));
    chk("shared pins", 32'({seg_data[28], 1'b0, seg_data[30], 1'b0}), 32'(shp));
    chk("segments", 32'(seg_data[27:0]), 32'(seg));
    chk("commons", 32'(8'h01 << phase), 32'(com));
    chk("panel lit", 32'h1, 32'(lit));
    tdone("led external drive");
    wr(SDC_IDX_CFG_A, 8'h58);
    repeat (3) @(posedge core_clk);
    chk("panel lit", 32'h0, 32'(lit));
    chk("commons", 32'h0, 32'(com));
    gap(512);
    wr(SDC_IDX_CFG_A, 8'h50);
    tdone("blanking");
    wr(SDC_IDX_DIV_HI, 8'h20);
    gap(20);
    wr(SDC_IDX_DIV_HI, 8'hA0);
    gap(28);
    tdone("lcd clock source");
    wr(SDC_IDX_CFG_B, 8'h02);
    wr(SDC_IDX_DIV_LO, 8'h00);
    wr(SDC_IDX_DIV_HI, 8'h60);
    seg_data <= 32'hC3A50F96;
    seq(5, 4'h2);
    repeat (3) @(posedge core_clk);
    chk("digit select", 32'(16'h0001 << phase), 32'(dig));
    chk("segments", 32'(seg_data[27:0]), 32'(seg));
    // In LED modes the display clock is the system clock, so a clear lands at once.
    wr(SDC_IDX_CFG_A, 8'h00);
    rdc(SDC_IDX_CFG_A, 8'h00);
    chk("commons", 32'h0, 32'(com));
    tdone("led direct drive");
    // Passing through off restarts the scan at phase 0, so a shorter frame never starts past its end.
    wr(SDC_IDX_DIV_HI, 8'h00);
    wr(SDC_IDX_CFG_B, 8'h01);
    wr(SDC_IDX_DIV_HI, 8'hA0);
    wr(SDC_IDX_CFG_A, 8'h00);
    repeat (120) @(posedge core_clk);
    rdc(SDC_IDX_CFG_A, 8'h01);
    chk("frame irq", 32'h0, 32'(irq));
    wr(SDC_IDX_CFG_A, 8'h03);
    repeat (3) @(posedge core_clk);
    chk("frame irq", 32'h1, 32'(irq));
    rdc(SDC_IDX_CFG_A, 8'h03);
    // Frames become rare here, so the pending clear is not undone by a new frame end.
    wr(SDC_IDX_DIV_LO, 8'hFF);
    wr(SDC_IDX_DIV_HI, 8'hAF);
    wr(SDC_IDX_CFG_A, 8'h02);
    repeat (60) @(posedge core_clk);
    rdc(SDC_IDX_CFG_A, 8'h02);
    chk("frame irq", 32'h0, 32'(irq));
    tdone("frame flag");
    wr(SDC_IDX_DIV_HI, 8'h00);
    repeat (4) @(posedge core_clk);
    p = phase;
    repeat (600) @(posedge core_clk);
    chk("phase when off", 32'(p), 32'(phase));
    chk("common overlap", 32'h0, 32'(overlap));
    tdone("disabled");
    final_report();
  end
endmodule
